// ### rtl/mec_map.svh
// Register offsets, reset values, masks and scaling steps of the
// motion event configuration bank.
// Assumes inclusion by the bank module and the bench top only.
`ifndef MEC_MAP_SVH
`define MEC_MAP_SVH

`define MEC_DEV_ADDR 7'h62

`define MEC_OFS_FALL_DELAY 8'h22
`define MEC_OFS_FALL_THRESHOLD 8'h23
`define MEC_OFS_FALL_HYST_MODE 8'h24
`define MEC_OFS_MOTION_DURATION 8'h27
`define MEC_OFS_MOTION_THRESHOLD 8'h28
`define MEC_OFS_TAP_TIMING 8'h2a
`define MEC_OFS_TAP_THRESHOLD 8'h2b
`define MEC_OFS_TILT_CONFIG 8'h2c
`define MEC_OFS_VERTICAL_SUPPRESS 8'h2d
`define MEC_OFS_X_TRIM 8'h38
`define MEC_OFS_Y_TRIM 8'h39
`define MEC_OFS_Z_TRIM 8'h3a
`define MEC_OFS_QUEUE_READ 8'hff

`define MEC_RST_FALL_DELAY 8'h09
`define MEC_RST_FALL_THRESHOLD 8'h30
`define MEC_RST_FALL_HYST_MODE 8'h01
`define MEC_RST_MOTION_DURATION 8'h00
`define MEC_RST_MOTION_THRESHOLD 8'h0a
`define MEC_RST_TAP_TIMING 8'h04
`define MEC_RST_TAP_THRESHOLD 8'h00
`define MEC_RST_TILT_CONFIG 8'h18
`define MEC_RST_VERTICAL_SUPPRESS 8'h08
`define MEC_RST_TRIM 8'h00

`define MEC_MSK_FALL_HYST_MODE 8'h07
`define MEC_MSK_MOTION_DURATION 8'h03
`define MEC_MSK_TAP_TIMING 8'hc7
`define MEC_MSK_TAP_THRESHOLD 8'h1f
`define MEC_MSK_TILT_CONFIG 8'h7f
`define MEC_MSK_VERTICAL_SUPPRESS 8'h0f

`define MEC_FALL_DELAY_STEP_MS 10'h002
`define MEC_FALL_STEP_UG 21'h001e82
`define MEC_FALL_HYST_STEP_MG 9'h07d
`define MEC_MOTION_STEP_2G_UG 23'h000f46
`define MEC_MOTION_STEP_4G_UG 23'h001e82
`define MEC_MOTION_STEP_8G_UG 23'h003d09
`define MEC_MOTION_STEP_16G_UG 23'h007a12
`define MEC_TAP_STEP_2G_UG 24'h00f424
`define MEC_TAP_STEP_4G_UG 24'h01e848
`define MEC_TAP_STEP_8G_UG 24'h03d090
`define MEC_TAP_STEP_16G_UG 24'h07a120
`define MEC_TILT_STEP_UG 19'h0f424
`define MEC_VERT_STEP_UG 20'h0f424
`define MEC_TAP_QUIET_LONG_MS 6'h1e
`define MEC_TAP_QUIET_SHORT_MS 6'h14
`define MEC_TAP_SHOCK_SHORT_MS 7'h32
`define MEC_TAP_SHOCK_LONG_MS 7'h46
`define MEC_TAP_WINDOW_TABLE {10'h2bc, 10'h1f4, 10'h177, 10'h0fa, \
                              10'h0c8, 10'h096, 10'h064, 10'h032}

`endif

// ### rtl/mec_pkg.sv
// Types shared by the motion event configuration bank.
// Assumes the map header sits beside it.
package mec_pkg;

   typedef enum logic {MEC_COMBINE_SINGLE, MEC_COMBINE_SUM} mec_combine_t;

   typedef enum logic [1:0] {
      MEC_SUPPRESS_NONE, MEC_SUPPRESS_Z, MEC_SUPPRESS_Z_SLOPE
   } mec_suppress_t;

   typedef enum logic [1:0] {
      MEC_SHAPE_SYMMETRIC, MEC_SHAPE_HIGH_ASYM, MEC_SHAPE_LOW_ASYM
   } mec_shape_t;

   typedef enum {
      MEC_ST_IDLE, MEC_ST_ADDR, MEC_ST_REG, MEC_ST_WR, MEC_ST_RD
   } mec_state_t;

   typedef struct packed {
      logic [9:0] fall_delay_ms;
      logic [20:0] fall_level_ug;
      mec_combine_t fall_combine;
      logic [8:0] fall_hysteresis_mg;
      logic [2:0] motion_duration_ms;
      logic [22:0] motion_level_ug;
      logic [5:0] tap_quiet_ms;
      logic [6:0] tap_shock_ms;
      logic [9:0] tap_window_ms;
      logic [23:0] tap_level_ug;
      logic [18:0] tilt_hysteresis_ug;
      mec_suppress_t tilt_suppress;
      mec_shape_t tilt_shape;
      logic [19:0] vertical_level_ug;
      logic [7:0] x_trim;
      logic [7:0] y_trim;
      logic [7:0] z_trim;
   } mec_cfg_t;

endpackage : mec_pkg

// ### rtl/mec_regs.sv
// Motion event configuration bank behind a two-wire serial slave port.
// Assumes scl_clk_in is the host's serial clock and all other inputs
// except sda_in come from logic on clk_in.
`include "mec_map.svh"
`timescale 1ns/100ps
`default_nettype none

module mec_regs
   import mec_pkg::*;
(
   // System
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Serial link
   input wire logic scl_clk_in,
   input wire logic sda_in,
   output logic sda_out_out,
   output logic sda_oe_out,
   // Device side
   input wire logic [1:0] full_scale_select_in,
   input wire logic [7:0] fifo_data_in,
   input wire logic [6:0] fifo_count_in,
   output logic fifo_pop_out,
   output mec_cfg_t cfg_out
);

   ////////////////////////////////////////////////////////////////////
   // Link domain: bits shifted on the serial clock
   logic [7:0] link_shift;

   always_ff @(posedge scl_clk_in) begin
      link_shift <= {link_shift[6:0], sda_in};
   end

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers and bus conditions
   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic scl_q;
   logic sda_q;
   logic start_det;
   logic stop_det;
   logic scl_rise;
   logic scl_fall;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], scl_clk_in};
         sda_sync <= {sda_sync[0], sda_in};
         scl_q <= scl_sync[1];
         sda_q <= sda_sync[1];
      end
   end

   assign start_det = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
   assign stop_det = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
   assign scl_rise = scl_sync[1] & ~scl_q;
   assign scl_fall = ~scl_sync[1] & scl_q;

   ////////////////////////////////////////////////////////////////////
   // Register storage
   logic [7:0] fall_delay;
   logic [7:0] fall_threshold;
   logic [7:0] fall_hysteresis_mode;
   logic [7:0] motion_duration_cfg;
   logic [7:0] motion_threshold_cfg;
   logic [7:0] tap_timing;
   logic [7:0] tap_threshold_cfg;
   logic [7:0] tilt_config;
   logic [7:0] vertical_suppress;
   logic [7:0] x_offset_trim;
   logic [7:0] y_offset_trim;
   logic [7:0] z_offset_trim;

   ////////////////////////////////////////////////////////////////////
   // Protocol state
   mec_state_t state;
   logic [3:0] bit_cnt;
   logic [7:0] reg_ptr;
   logic [7:0] tx_shift;
   logic host_acked;
   logic sda_oe;
   logic wr_fire;
   logic rd_fire;
   logic [7:0] rd_data;
   logic [7:0] next_ptr;

   assign wr_fire = scl_fall & (state == MEC_ST_WR) & (bit_cnt == 4'h8);
   assign rd_fire = scl_fall & (state == MEC_ST_RD) & (bit_cnt == 4'h9)
                    & host_acked;
   assign next_ptr = (reg_ptr == `MEC_OFS_QUEUE_READ) ? reg_ptr
                     : reg_ptr + 8'h01;

   // Read multiplexer
   always_comb begin
      unique case (reg_ptr)
         `MEC_OFS_FALL_DELAY: rd_data = fall_delay;
         `MEC_OFS_FALL_THRESHOLD: rd_data = fall_threshold;
         `MEC_OFS_FALL_HYST_MODE: rd_data = fall_hysteresis_mode;
         `MEC_OFS_MOTION_DURATION: rd_data = motion_duration_cfg;
         `MEC_OFS_MOTION_THRESHOLD: rd_data = motion_threshold_cfg;
         `MEC_OFS_TAP_TIMING: rd_data = tap_timing;
         `MEC_OFS_TAP_THRESHOLD: rd_data = tap_threshold_cfg;
         `MEC_OFS_TILT_CONFIG: rd_data = tilt_config;
         `MEC_OFS_VERTICAL_SUPPRESS: rd_data = vertical_suppress;
         `MEC_OFS_X_TRIM: rd_data = x_offset_trim;
         `MEC_OFS_Y_TRIM: rd_data = y_offset_trim;
         `MEC_OFS_Z_TRIM: rd_data = z_offset_trim;
         `MEC_OFS_QUEUE_READ: rd_data = (fifo_count_in == 7'h00) ? 8'h00
                                        : fifo_data_in;
         default: rd_data = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Byte framing qualifiers
   logic rise_act;
   logic fall_act;
   logic byte_end;
   logic ack_end;
   logic bit_slot;
   logic addr_match;

   assign rise_act = scl_rise & (state != MEC_ST_IDLE) & ~start_det
                     & ~stop_det;
   assign fall_act = scl_fall & (state != MEC_ST_IDLE) & ~start_det
                     & ~stop_det;
   assign byte_end = fall_act & (bit_cnt == 4'h8);
   assign ack_end = fall_act & (bit_cnt == 4'h9);
   assign bit_slot = fall_act & (state == MEC_ST_RD) & (bit_cnt != 4'h0)
                     & (bit_cnt < 4'h8);
   assign addr_match = (link_shift[7:1] == `MEC_DEV_ADDR);

   ////////////////////////////////////////////////////////////////////
   // Bit counter
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         bit_cnt <= 4'h0;
      end else if (start_det || stop_det) begin
         bit_cnt <= 4'h0;
      end else if (rise_act) begin
         bit_cnt <= bit_cnt + 4'h1;
      end else if (ack_end) begin
         bit_cnt <= 4'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Transfer state
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state <= MEC_ST_IDLE;
      end else if (start_det) begin
         state <= MEC_ST_ADDR;
      end else if (stop_det) begin
         state <= MEC_ST_IDLE;
      end else if (byte_end) begin
         unique case (state)
            MEC_ST_ADDR: begin
               if (addr_match) begin
                  state <= link_shift[0] ? MEC_ST_RD : MEC_ST_REG;
               end else begin
                  state <= MEC_ST_IDLE;
               end
            end
            MEC_ST_REG: begin
               state <= MEC_ST_WR;
            end
            default: begin
            end
         endcase
      end else if (ack_end && !rd_fire && state == MEC_ST_RD) begin
         state <= MEC_ST_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Host acknowledge after a read byte
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         host_acked <= 1'b0;
      end else if (rise_act && bit_cnt == 4'h8) begin
         host_acked <= ~link_shift[0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Register pointer
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         reg_ptr <= 8'h00;
      end else if (byte_end && state == MEC_ST_REG) begin
         reg_ptr <= link_shift;
      end else if (byte_end && state == MEC_ST_WR) begin
         reg_ptr <= next_ptr;
      end else if (ack_end && rd_fire) begin
         reg_ptr <= next_ptr;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read data shifter
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         tx_shift <= 8'h00;
      end else if (ack_end && rd_fire) begin
         tx_shift <= {rd_data[6:0], 1'b0};
      end else if (bit_slot) begin
         tx_shift <= {tx_shift[6:0], 1'b0};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Data line pull-down, set and released after SCL has fallen; cleared at once on a start or stop
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         sda_oe <= 1'b0;
      end else if (start_det || stop_det) begin
         sda_oe <= 1'b0;
      end else if (byte_end) begin
         unique case (state)
            MEC_ST_ADDR: begin
               if (addr_match) begin
                  sda_oe <= 1'b1;
               end
            end
            MEC_ST_REG, MEC_ST_WR: begin
               sda_oe <= 1'b1;
            end
            default: begin
               sda_oe <= 1'b0;
            end
         endcase
      end else if (ack_end) begin
         sda_oe <= rd_fire ? ~rd_data[7] : 1'b0;
      end else if (bit_slot) begin
         sda_oe <= ~tx_shift[7];
      end
   end

   assign sda_oe_out = sda_oe;
   assign sda_out_out = 1'b0;

   ////////////////////////////////////////////////////////////////////
   // Queue pop strobe
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         fifo_pop_out <= 1'b0;
      end else begin
         fifo_pop_out <= rd_fire & (reg_ptr == `MEC_OFS_QUEUE_READ)
                         & (fifo_count_in != 7'h00);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Register writes
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         fall_delay <= `MEC_RST_FALL_DELAY;
         fall_threshold <= `MEC_RST_FALL_THRESHOLD;
         fall_hysteresis_mode <= `MEC_RST_FALL_HYST_MODE;
         motion_duration_cfg <= `MEC_RST_MOTION_DURATION;
         motion_threshold_cfg <= `MEC_RST_MOTION_THRESHOLD;
         tap_timing <= `MEC_RST_TAP_TIMING;
         tap_threshold_cfg <= `MEC_RST_TAP_THRESHOLD;
         tilt_config <= `MEC_RST_TILT_CONFIG;
         vertical_suppress <= `MEC_RST_VERTICAL_SUPPRESS;
         x_offset_trim <= `MEC_RST_TRIM;
         y_offset_trim <= `MEC_RST_TRIM;
         z_offset_trim <= `MEC_RST_TRIM;
      end else if (wr_fire) begin
         unique case (reg_ptr)
            `MEC_OFS_FALL_DELAY: fall_delay <= link_shift;
            `MEC_OFS_FALL_THRESHOLD: fall_threshold <= link_shift;
            `MEC_OFS_FALL_HYST_MODE:
               fall_hysteresis_mode <= link_shift & `MEC_MSK_FALL_HYST_MODE;
            `MEC_OFS_MOTION_DURATION:
               motion_duration_cfg <= link_shift & `MEC_MSK_MOTION_DURATION;
            `MEC_OFS_MOTION_THRESHOLD: motion_threshold_cfg <= link_shift;
            `MEC_OFS_TAP_TIMING:
               tap_timing <= link_shift & `MEC_MSK_TAP_TIMING;
            `MEC_OFS_TAP_THRESHOLD:
               tap_threshold_cfg <= link_shift & `MEC_MSK_TAP_THRESHOLD;
            `MEC_OFS_TILT_CONFIG:
               tilt_config <= link_shift & `MEC_MSK_TILT_CONFIG;
            `MEC_OFS_VERTICAL_SUPPRESS:
               vertical_suppress <= link_shift & `MEC_MSK_VERTICAL_SUPPRESS;
            `MEC_OFS_X_TRIM: x_offset_trim <= link_shift;
            `MEC_OFS_Y_TRIM: y_offset_trim <= link_shift;
            `MEC_OFS_Z_TRIM: z_offset_trim <= link_shift;
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Decoded settings for the detectors
   logic [22:0] motion_step;
   logic [23:0] tap_step;
   logic [79:0] window_table;

   assign window_table = `MEC_TAP_WINDOW_TABLE;

   always_comb begin
      unique case (full_scale_select_in)
         2'h0: begin
            motion_step = `MEC_MOTION_STEP_2G_UG;
            tap_step = `MEC_TAP_STEP_2G_UG;
         end
         2'h1: begin
            motion_step = `MEC_MOTION_STEP_4G_UG;
            tap_step = `MEC_TAP_STEP_4G_UG;
         end
         2'h2: begin
            motion_step = `MEC_MOTION_STEP_8G_UG;
            tap_step = `MEC_TAP_STEP_8G_UG;
         end
         2'h3: begin
            motion_step = `MEC_MOTION_STEP_16G_UG;
            tap_step = `MEC_TAP_STEP_16G_UG;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cfg_out <= '0;
      end else begin
         cfg_out.fall_delay_ms <= 10'({2'h0, fall_delay} + 10'h001)
                                  * `MEC_FALL_DELAY_STEP_MS;
         cfg_out.fall_level_ug <= 21'(fall_threshold)
                                  * `MEC_FALL_STEP_UG;
         cfg_out.fall_combine <= fall_hysteresis_mode[2]
                                 ? MEC_COMBINE_SUM
                                 : MEC_COMBINE_SINGLE;
         cfg_out.fall_hysteresis_mg <= 9'(fall_hysteresis_mode[1:0])
                                       * `MEC_FALL_HYST_STEP_MG;
         cfg_out.motion_duration_ms <= {1'b0, motion_duration_cfg[1:0]}
                                       + 3'h1;
         cfg_out.motion_level_ug <= 23'(motion_threshold_cfg)
                                    * motion_step;
         cfg_out.tap_quiet_ms <= tap_timing[7] ? `MEC_TAP_QUIET_SHORT_MS
                                 : `MEC_TAP_QUIET_LONG_MS;
         cfg_out.tap_shock_ms <= tap_timing[6] ? `MEC_TAP_SHOCK_LONG_MS
                                 : `MEC_TAP_SHOCK_SHORT_MS;
         cfg_out.tap_window_ms <= window_table[10*tap_timing[2:0] +: 10];
         cfg_out.tap_level_ug <= 24'(tap_threshold_cfg[4:0])
                                 * tap_step;
         cfg_out.tilt_hysteresis_ug <= 19'(tilt_config[6:4])
                                       * `MEC_TILT_STEP_UG;
         unique case (tilt_config[3:2])
            2'h1: cfg_out.tilt_suppress <= MEC_SUPPRESS_Z;
            2'h2: cfg_out.tilt_suppress <= MEC_SUPPRESS_Z_SLOPE;
            default: cfg_out.tilt_suppress <= MEC_SUPPRESS_NONE;
         endcase
         unique case (tilt_config[1:0])
            2'h1: cfg_out.tilt_shape <= MEC_SHAPE_HIGH_ASYM;
            2'h2: cfg_out.tilt_shape <= MEC_SHAPE_LOW_ASYM;
            default: cfg_out.tilt_shape <= MEC_SHAPE_SYMMETRIC;
         endcase
         cfg_out.vertical_level_ug <= 20'(vertical_suppress[3:0])
                                      * `MEC_VERT_STEP_UG;
         cfg_out.x_trim <= x_offset_trim;
         cfg_out.y_trim <= y_offset_trim;
         cfg_out.z_trim <= z_offset_trim;
      end
   end

endmodule : mec_regs

`default_nettype wire

// ### bench/mec_regs_assertions.sv
// Checker on the ports of the configuration bank.
// Assumes binding into mec_regs; SCL is sampled as plain data.
`timescale 1ns/100ps
`default_nettype none
module mec_regs_chk
   import mec_pkg::*;
(
   // System
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Link
   input wire logic scl_clk_in,
   input wire logic sda_in,
   input wire logic sda_out_out,
   input wire logic sda_oe_out,
   // Device side
   input wire logic [1:0] full_scale_select_in,
   input wire logic [7:0] fifo_data_in,
   input wire logic [6:0] fifo_count_in,
   input wire logic fifo_pop_out,
   input wire mec_cfg_t cfg_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////////////////////////
   a_sda_value: assert property (sda_oe_out |-> !sda_out_out)
      else $error("sda drives high");
   a_reset_quiet: assert property (disable iff (1'b0)
      !rst_n_in |=> !sda_oe_out && !fifo_pop_out) else $error("reset busy");
   a_cfg_reset: assert property ($rose(rst_n_in) |-> ##2
      (cfg_out.fall_delay_ms == 10'h014 &&
      cfg_out.vertical_level_ug == 20'h7a120)) else $error("cfg reset");
   a_oe_scl_low: assert property ($changed(sda_oe_out) |->
      !scl_clk_in && $past(scl_clk_in, 2) == 1'b0) else $error("oe timing");
   a_ack_stands: assert property ($rose(sda_oe_out) |=>
      sda_oe_out [*8]) else $error("ack short");
   a_pop_pulse: assert property (fifo_pop_out |=> !fifo_pop_out)
      else $error("pop long");
   a_pop_nonempty: assert property (fifo_pop_out |->
      $past(fifo_count_in) != 7'h00) else $error("pop empty");
   a_tap_codes: assert property ($past(rst_n_in) && $past(rst_n_in, 2) |->
      cfg_out.tap_window_ms inside {10'h032, 10'h064, 10'h096, 10'h0c8,
      10'h0fa, 10'h177, 10'h1f4, 10'h2bc} &&
      cfg_out.tap_quiet_ms inside {6'h14, 6'h1e} &&
      cfg_out.tap_shock_ms inside {7'h32, 7'h46}) else $error("tap code");
   a_tilt_codes: assert property ($past(rst_n_in, 2) |->
      cfg_out.tilt_suppress != 2'h3 && cfg_out.tilt_shape != 2'h3)
      else $error("tilt code");
   a_fall_codes: assert property ($past(rst_n_in, 2) |->
      cfg_out.fall_hysteresis_mg inside {9'h000, 9'h07d, 9'h0fa, 9'h177}
      && cfg_out.motion_duration_ms inside {[3'h1:3'h4]})
      else $error("fall code");
   a_scale_step: assert property (full_scale_select_in == 2'h3 &&
      $past(full_scale_select_in, 2) == 2'h3 |->
      cfg_out.motion_level_ug % 23'h007a12 == 0 &&
      cfg_out.tap_level_ug % 24'h07a120 == 0) else $error("scale");
   c_pop: cover property (fifo_pop_out);
   c_ack: cover property ($rose(sda_oe_out));
   c_scale: cover property (full_scale_select_in == 2'h3);
endmodule : mec_regs_chk
bind mec_regs mec_regs_chk u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .scl_clk_in(scl_clk_in), .sda_in(sda_in), .sda_out_out(sda_out_out),
   .sda_oe_out(sda_oe_out), .full_scale_select_in(full_scale_select_in),
   .fifo_data_in(fifo_data_in), .fifo_count_in(fifo_count_in),
   .fifo_pop_out(fifo_pop_out), .cfg_out(cfg_out));
`default_nettype wire

// ### bench/mec_host.sv
// Behavioural host master of the two-wire link.
// Assumes a pull-up on SDA; SCL stands high between frames.
`timescale 1ns/100ps
`default_nettype none
module mec_host (
   // Link
   output logic scl_out,
   output logic sda_oe_out,
   input wire logic sda_in,
   // Pace
   input wire logic slow_in
);
   int lo;
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end
   always_comb lo = slow_in ? 1600 : 1200;
   ////////////////////////////////////////////////////////////
   task automatic bit_io(input logic b, output logic r);
      sda_oe_out = ~b;
      #(lo);
      scl_out = 1'b1;
      #300;
      r = sda_in;
      #300;
      scl_out = 1'b0;
      #100;
   endtask : bit_io
   task automatic start_cond();
      sda_oe_out = 1'b0;
      #(lo);
      scl_out = 1'b1;
      #700;
      sda_oe_out = 1'b1;
      #700;
      scl_out = 1'b0;
      #100;
   endtask : start_cond
   task automatic stop_cond();
      sda_oe_out = 1'b1;
      #(lo);
      scl_out = 1'b1;
      #700;
      sda_oe_out = 1'b0;
      #1400;
   endtask : stop_cond
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask : put_byte
   task automatic get_byte(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         b[i] = r;
      end
      bit_io(last, r);
   endtask : get_byte
endmodule : mec_host
`default_nettype wire

// ### bench/tb_top.sv
// Bench for the bank: host model on the link, queue model on the side.
// Assumes the map header on the include path.
`include "mec_map.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top
   import mec_pkg::*;
;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [1:0] fs = 2'h0;
   logic [7:0] fq_data = 8'ha5;
   logic [6:0] fq_count = 7'h00;
   logic slow = 1'b0;
   logic scl, host_oe, dut_o, dut_oe, pop, sda, ack;
   mec_cfg_t cfg;
   int n_fail = 0;
   int checks = 0;
   logic [7:0] got [32];
   logic [9:0] win [8] = '{10'h032, 10'h064, 10'h096, 10'h0c8, 10'h0fa,
      10'h177, 10'h1f4, 10'h2bc};
   logic [22:0] ms [4] = '{23'h000f46, 23'h001e82, 23'h003d09, 23'h007a12};
   logic [23:0] ts [4] = '{24'h00f424, 24'h01e848, 24'h03d090, 24'h07a120};
   logic [11:0] tilt [3] = '{12'h926, 12'h619, 12'h070};
   always #10 clk_in = ~clk_in;
   assign sda = ~(host_oe | (dut_oe & ~dut_o));
   mec_host u_host (.scl_out(scl), .sda_oe_out(host_oe), .sda_in(sda),
      .slow_in(slow));
   mec_regs u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .scl_clk_in(scl),
      .sda_in(sda), .sda_out_out(dut_o), .sda_oe_out(dut_oe),
      .full_scale_select_in(fs), .fifo_data_in(fq_data),
      .fifo_count_in(fq_count), .fifo_pop_out(pop), .cfg_out(cfg));
   always @(negedge clk_in) begin
      if (pop) begin
         fq_count <= fq_count - 7'h01;
         fq_data <= fq_data + 8'h11;
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic head(input logic [7:0] a);
      u_host.start_cond();
      u_host.put_byte({`MEC_DEV_ADDR, 1'b0}, ack);
      `CHK(ack, 1'b1)
      u_host.put_byte(a, ack);
      `CHK(ack, 1'b1)
   endtask : head
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input int n);
      head(a);
      for (int i = 0; i < n; i++) begin
         u_host.put_byte(d, ack);
         `CHK(ack, 1'b1)
      end
      u_host.stop_cond();
   endtask : wr
   task automatic rd(input logic [7:0] a, input int n);
      head(a);
      u_host.start_cond();
      u_host.put_byte({`MEC_DEV_ADDR, 1'b1}, ack);
      `CHK(ack, 1'b1)
      for (int i = 0; i < n; i++) begin
         u_host.get_byte(i == n - 1, got[i]);
      end
      u_host.stop_cond();
   endtask : rd
   function automatic logic [7:0] ones(input logic [7:0] a);
      case (a)
         8'h22, 8'h23, 8'h28, 8'h38, 8'h39, 8'h3a: ones = 8'hff;
         8'h24: ones = 8'h07;
         8'h27: ones = 8'h03;
         8'h2a: ones = 8'hc7;
         8'h2b: ones = 8'h1f;
         8'h2c: ones = 8'h7f;
         8'h2d: ones = 8'h0f;
         default: ones = 8'h00;
      endcase
   endfunction : ones
   task automatic give_verdict();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict
   ////////////////////////////////////////////////////////////
   initial begin
      #2000000;
      n_fail++;
      give_verdict();
   end
   initial begin
      repeat (10) @(negedge clk_in);
      rst_n_in = 1'b1;
      repeat (5) @(negedge clk_in);
      `CHK(cfg.fall_delay_ms, 10'h014)
      `CHK(cfg.fall_level_ug, 21'h05b860)
      `CHK(cfg.fall_combine, MEC_COMBINE_SINGLE)
      `CHK(cfg.fall_hysteresis_mg, 9'h07d)
      `CHK(cfg.motion_duration_ms, 3'h1)
      `CHK(cfg.tap_window_ms, 10'h0fa)
      `CHK(cfg.tilt_hysteresis_ug, 19'h0f424)
      `CHK(cfg.tilt_suppress, MEC_SUPPRESS_Z_SLOPE)
      `CHK(cfg.vertical_level_ug, 20'h7a120)
      `CHK(cfg.x_trim, 8'h00)
      $display("test reset done");
      wr(8'h22, 8'hff, 25);
      rd(8'h22, 25);
      for (int i = 0; i < 25; i++) begin
         `CHK(got[i], ones(8'h22 + i[7:0]))
      end
      `CHK(cfg.fall_delay_ms, 10'h200)
      `CHK(cfg.fall_level_ug, 21'h1e637e)
      `CHK(cfg.fall_combine, MEC_COMBINE_SUM)
      `CHK(cfg.fall_hysteresis_mg, 9'h177)
      `CHK(cfg.motion_duration_ms, 3'h4)
      `CHK(cfg.tilt_hysteresis_ug, 19'h6acfc)
      `CHK(cfg.tilt_suppress, MEC_SUPPRESS_NONE)
      `CHK(cfg.tilt_shape, MEC_SHAPE_SYMMETRIC)
      `CHK(cfg.vertical_level_ug, 20'he4e1c)
      `CHK(cfg.z_trim, 8'hff)
      for (int f = 0; f < 4; f++) begin
         fs = f[1:0];
         repeat (4) @(negedge clk_in);
         `CHK(cfg.motion_level_ug, ms[f] * 23'h0000ff)
         `CHK(cfg.tap_level_ug, ts[f] * 24'h00001f)
      end
      $display("test burst done");
      for (int k = 0; k < 3; k++) begin
         wr(8'h2c, tilt[k][7:0], 1);
         `CHK(cfg.tilt_suppress, tilt[k][9:8])
         `CHK(cfg.tilt_shape, tilt[k][11:10])
      end
      for (int i = 0; i < 8; i++) begin
         wr(8'h2a, {i[0], i[1], 3'h0, i[2:0]}, 1);
         `CHK(cfg.tap_window_ms, win[i])
         `CHK(cfg.tap_quiet_ms, i[0] ? 6'h14 : 6'h1e)
         `CHK(cfg.tap_shock_ms, i[1] ? 7'h46 : 7'h32)
      end
      $display("test codes done");
      u_host.start_cond();
      u_host.put_byte({7'h63, 1'b0}, ack);
      `CHK(ack, 1'b0)
      u_host.put_byte(8'h38, ack);
      u_host.put_byte(8'h00, ack);
      u_host.stop_cond();
      rd(8'h38, 1);
      `CHK(got[0], 8'hff)
      slow = 1'b1;
      fq_count = 7'h02;
      rd(8'hff, 3);
      `CHK(got[0], 8'ha5)
      `CHK(got[1], 8'hb6)
      `CHK(got[2], 8'h00)
      `CHK(fq_count, 7'h00)
      $display("test link done");
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
